/* File: hdl/scw_pkg.sv */
// constants and decode codes for the serial control word decoder
package scw_pkg;
  localparam int unsigned WORD_W   = 16;
  localparam int unsigned CNT_W    = 4;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned GRP_LSB  = 3;
  localparam int unsigned SET_LSB  = 5;
  localparam int unsigned REG2_BIT = 14;
  localparam int unsigned WDOG_BIT = 15;
  localparam int unsigned CYC_W    = 5;
  localparam int unsigned WDP_W    = 6;
  localparam int unsigned MON_N    = 4;
  localparam logic [15:0] CTRL_RST = 16'h0003;
  localparam logic [2:0] MODE_RSVD = 3'h0;
  localparam logic [2:0] MODE_CANSLP = 3'h1;
  localparam logic [2:0] MODE_LINSLP = 3'h2;
  localparam logic [2:0] MODE_ACT  = 3'h3;
  localparam logic [2:0] MODE_SLEEP = 3'h4;
  localparam logic [2:0] MODE_CANRO = 3'h5;
  localparam logic [2:0] MODE_LINRO = 3'h6;
  localparam logic [2:0] MODE_STOP = 3'h7;
  localparam logic [1:0] GRP_GEN   = 2'h0;
  localparam logic [1:0] GRP_HS    = 2'h1;
  localparam logic [1:0] GRP_CYC   = 2'h2;
  localparam logic [1:0] GRP_WDG   = 2'h3;
endpackage

/* File: hdl/scw_decoder.sv */
// serial control word slave port and decoder
module scw_decoder #(
  parameter bit MSB_FIRST = 1'b0
) (
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        sclk_in,
  input  wire logic        select_n_in,
  input  wire logic        serial_data_in,
  input  wire logic        supply_fail_in,
  input  wire logic [15:0] status_active_in,
  input  wire logic [15:0] status_wake_in,
  input  wire logic        wake_event_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_out,
  output logic             wake_output_n_out,
  output logic [15:0]      control_word_out,
  output logic             word_valid_out,
  output logic             can_on_out,
  output logic             lin_on_out,
  output logic             can_rxonly_out,
  output logic             lin_rxonly_out,
  output logic             chip_sleep_out,
  output logic             chip_stop_out,
  output logic             second_regulator_out,
  output logic             watchdog_on_out,
  output logic             reset_level_high_out,
  output logic             reset_delay_short_out,
  output logic             lin_low_slope_out,
  output logic [3:0]       wake_pin_en_out,
  output logic             sense_on_out,
  output logic             high_side_output_out,
  output logic [4:0]       cyclic_period_out,
  output logic             cyclic_wake_out,
  output logic             hs_ontime_short_out,
  output logic             hs_off_by_ontime_out,
  output logic             cont_timer_out,
  output logic [5:0]       wdog_period_out,
  output logic             wdog_trigger_out
);
  // ***********************************
  // link domain (serial clock)
  // ***********************************
  logic [15:0] rx_q;
  logic [3:0]  cnt_q;
  logic [15:0] tx_q;
  logic        err_tgl_l_q;
  logic [1:0]  ack_l_q;
  logic        err_lvl_q;
  logic        wake_rpt_q;
  logic        first_q;

  always_ff @(negedge sclk_in) begin
    if (!select_n_in) begin
      if (MSB_FIRST) begin
        rx_q <= {rx_q[14:0], serial_data_in};
      end else begin
        rx_q <= {serial_data_in, rx_q[15:1]};
      end
    end
  end

  always_ff @(negedge sclk_in or posedge select_n_in) begin
    if (select_n_in) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_ff @(posedge sclk_in or posedge select_n_in) begin
    if (select_n_in) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  logic [15:0] status_sel;
  assign status_sel = wake_rpt_q ? status_wake_in : status_active_in;

  always_ff @(posedge sclk_in) begin
    if (first_q) begin
      tx_q <= MSB_FIRST ? {status_sel[14:0], 1'b0} : {1'b0, status_sel[15:1]};
    end else begin
      tx_q <= MSB_FIRST ? {tx_q[14:0], 1'b0} : {1'b0, tx_q[15:1]};
    end
  end

  logic first_bit;
  assign first_bit = MSB_FIRST ? status_sel[15] : status_sel[0];

  logic [15:0] commit_q;
  logic        bad_q;
  always_ff @(posedge select_n_in) begin
    commit_q     <= rx_q;
    bad_q        <= (cnt_q != 4'h0);
  end

  // error level seen by next frame
  always_ff @(negedge select_n_in) begin
    err_lvl_q  <= bad_q;
    wake_rpt_q <= wake_event_in;
  end

  // ***********************************
  // crossing into system clock
  // ***********************************
  logic [2:0] sel_sync_q;
  logic [1:0] sel_hold;
  logic [15:0] ctrl_q;

  // select synchroniser, idle high after reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sel_sync_q <= 3'h7;
    end else begin
      sel_sync_q <= {sel_sync_q[1:0], select_n_in};
    end
  end

  // commit on synchronised select rise; word and flag stand by then
  logic commit_ev;
  assign commit_ev = sel_sync_q[1] & ~sel_sync_q[2];
  assign sel_hold  = sel_sync_q[2:1];

  logic commit_ok_q;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      commit_ok_q <= 1'b0;
    end else begin
      commit_ok_q <= commit_ev && !bad_q;
    end
  end

  logic [2:0] mode_c;
  logic [1:0] grp_c;
  assign mode_c = ctrl_q[scw_pkg::MODE_LSB +: 3];
  assign grp_c  = ctrl_q[scw_pkg::GRP_LSB +: 2];

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || supply_fail_in) begin
      ctrl_q <= scw_pkg::CTRL_RST;
    end else if (commit_ev && !bad_q) begin
      ctrl_q <= commit_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wake_output_n_out <= 1'b1;
    end else if (commit_ev) begin
      wake_output_n_out <= !bad_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wdog_trigger_out <= 1'b0;
    end else begin
      wdog_trigger_out <= commit_ok_q
                          && ctrl_q[scw_pkg::GRP_LSB +: 2] == scw_pkg::GRP_WDG;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      serial_data_oe_out <= 1'b0;
      serial_data_out    <= 1'b0;
    end else begin
      serial_data_oe_out <= !sel_hold[1];
      serial_data_out    <= first_q ? (err_lvl_q | first_bit)
                            : (MSB_FIRST ? tx_q[15] : tx_q[0]);
    end
  end

  // ***********************************
  // field decode
  // ***********************************
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      control_word_out <= scw_pkg::CTRL_RST;
      word_valid_out   <= 1'b1;
      can_on_out       <= 1'b1;
      lin_on_out       <= 1'b1;
      can_rxonly_out   <= 1'b0;
      lin_rxonly_out   <= 1'b0;
      chip_sleep_out   <= 1'b0;
      chip_stop_out    <= 1'b0;
      second_regulator_out <= 1'b1;
      watchdog_on_out  <= 1'b1;
    end else begin
      control_word_out <= ctrl_q;
      word_valid_out   <= mode_c != scw_pkg::MODE_RSVD;
      can_on_out     <= mode_c == scw_pkg::MODE_LINSLP || mode_c == scw_pkg::MODE_ACT
                        || mode_c == scw_pkg::MODE_LINRO;
      lin_on_out     <= mode_c == scw_pkg::MODE_CANSLP || mode_c == scw_pkg::MODE_ACT
                        || mode_c == scw_pkg::MODE_CANRO;
      can_rxonly_out <= mode_c == scw_pkg::MODE_CANRO;
      lin_rxonly_out <= mode_c == scw_pkg::MODE_LINRO;
      chip_sleep_out <= mode_c == scw_pkg::MODE_SLEEP;
      chip_stop_out  <= mode_c == scw_pkg::MODE_STOP;
      if (mode_c == scw_pkg::MODE_SLEEP || mode_c == scw_pkg::MODE_STOP) begin
        second_regulator_out <= ctrl_q[scw_pkg::REG2_BIT];
        watchdog_on_out      <= ctrl_q[scw_pkg::WDOG_BIT];
      end else begin
        second_regulator_out <= 1'b1;
        watchdog_on_out      <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || supply_fail_in) begin
      reset_level_high_out  <= 1'b0;
      reset_delay_short_out <= 1'b0;
      lin_low_slope_out     <= 1'b0;
      wake_pin_en_out       <= 4'h0;
      sense_on_out          <= 1'b0;
      high_side_output_out  <= 1'b0;
      cyclic_period_out     <= 5'h00;
      cyclic_wake_out       <= 1'b0;
      hs_ontime_short_out   <= 1'b0;
      hs_off_by_ontime_out  <= 1'b0;
      cont_timer_out        <= 1'b0;
      wdog_period_out       <= 6'h01;
    end else begin
      unique case (grp_c)
        scw_pkg::GRP_GEN: begin
          reset_level_high_out  <= ctrl_q[scw_pkg::SET_LSB];
          reset_delay_short_out <= ctrl_q[scw_pkg::SET_LSB + 1];
          lin_low_slope_out     <= ctrl_q[scw_pkg::SET_LSB + 2];
          wake_pin_en_out       <= ctrl_q[scw_pkg::SET_LSB + 3 +: scw_pkg::MON_N];
          sense_on_out          <= ctrl_q[scw_pkg::SET_LSB + 7];
        end
        scw_pkg::GRP_HS: begin
          high_side_output_out  <= ctrl_q[scw_pkg::SET_LSB];
        end
        scw_pkg::GRP_CYC: begin
          cyclic_period_out     <= ctrl_q[scw_pkg::SET_LSB +: scw_pkg::CYC_W];
          cyclic_wake_out       <= ctrl_q[scw_pkg::SET_LSB + 5];
          hs_ontime_short_out   <= ctrl_q[scw_pkg::SET_LSB + 6];
          hs_off_by_ontime_out  <= ctrl_q[scw_pkg::SET_LSB + 7];
          cont_timer_out        <= ctrl_q[scw_pkg::SET_LSB + 8];
        end
        scw_pkg::GRP_WDG: begin
          if (ctrl_q[scw_pkg::SET_LSB +: scw_pkg::WDP_W] != 6'h00) begin
            wdog_period_out <= ctrl_q[scw_pkg::SET_LSB +: scw_pkg::WDP_W];
          end
        end
      endcase
    end
  end
endmodule

/* File: testbench/scw_decoder_sva.sv */
// assertion checker for the serial control word decoder
module scw_decoder_sva (
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        select_n_in,
  input wire logic        serial_data_oe_out,
  input wire logic [15:0] control_word_out,
  input wire logic        word_valid_out,
  input wire logic        can_on_out,
  input wire logic        lin_on_out,
  input wire logic        can_rxonly_out,
  input wire logic        chip_sleep_out,
  input wire logic        chip_stop_out,
  input wire logic        second_regulator_out,
  input wire logic        watchdog_on_out,
  input wire logic [5:0]  wdog_period_out,
  input wire logic        wdog_trigger_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  logic [2:0] mode_w;
  logic       psave_w;
  assign mode_w  = control_word_out[2:0];
  assign psave_w = (mode_w == scw_pkg::MODE_SLEEP) || (mode_w == scw_pkg::MODE_STOP);
  a_oe_release: assert property ($rose(select_n_in) |-> ##[1:6] !serial_data_oe_out)
    else $error("data out still driven after select rise");
  a_mode_valid: assert property ($stable(control_word_out) |->
    word_valid_out == (mode_w != scw_pkg::MODE_RSVD)) else $error("valid flag wrong");
  a_sleep_dec: assert property ($stable(control_word_out) |->
    chip_sleep_out == (mode_w == scw_pkg::MODE_SLEEP)) else $error("sleep decode wrong");
  a_stop_dec: assert property ($stable(control_word_out) |->
    chip_stop_out == (mode_w == scw_pkg::MODE_STOP)) else $error("stop decode wrong");
  a_canon_dec: assert property ($stable(control_word_out) |->
    can_on_out == (mode_w == scw_pkg::MODE_LINSLP || mode_w == scw_pkg::MODE_ACT
    || mode_w == scw_pkg::MODE_LINRO)) else $error("can on decode wrong");
  a_linon_dec: assert property ($stable(control_word_out) |->
    lin_on_out == (mode_w == scw_pkg::MODE_CANSLP || mode_w == scw_pkg::MODE_ACT
    || mode_w == scw_pkg::MODE_CANRO)) else $error("lin on decode wrong");
  a_canro_dec: assert property ($stable(control_word_out) |->
    can_rxonly_out == (mode_w == scw_pkg::MODE_CANRO)) else $error("rx-only decode wrong");
  a_reg2_keep: assert property ($stable(control_word_out) |->
    second_regulator_out == (psave_w ? control_word_out[14] : 1'b1))
    else $error("regulator keep wrong");
  a_wdog_keep: assert property ($stable(control_word_out) |->
    watchdog_on_out == (psave_w ? control_word_out[15] : 1'b1)) else $error("watchdog keep wrong");
  a_trig_pulse: assert property (wdog_trigger_out |->
    control_word_out[4:3] == scw_pkg::GRP_WDG ##1 !wdog_trigger_out)
    else $error("trigger not a watchdog group pulse");
  a_wdp_nonzero: assert property (wdog_period_out != 6'h00)
    else $error("watchdog period zero");
  a_reset_word: assert property ($fell(sys_rst_in) |->
    control_word_out == scw_pkg::CTRL_RST && wdog_period_out == 6'h01)
    else $error("reset values wrong");
endmodule

bind scw_decoder scw_decoder_sva scw_decoder_sva_inst (.*);

/* File: testbench/scw_master.sv */
// serial master model driving select, clock and data
module scw_master (
  output logic sclk_out,
  output logic select_n_out,
  output logic sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out     = 1'b0;
    select_n_out = 1'b1;
    sdi_out      = 1'b1;
  end
  task automatic frame(input logic [15:0] word, input int nclk);
    select_n_out = 1'b0;
    #80;
    for (int i = 0; i < nclk; i++) begin
      sdi_out = word[i % 16];
      #40 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
      #40;
    end
    #40 select_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #400;
  endtask
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the serial control word decoder
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] word;
    logic [5:0]  nclk;
    logic [15:0] cw;
    logic        wake_n;
    logic [6:0]  modes;
    logic [23:0] set;
    logic [23:0] mask;
  } scw_row_s;
  logic        mclk_in, sys_rst_in, supply_fail_in, sclk, sel_n, sdi;
  logic        sdo, oe, wake_n, valid, canro, linro, sleep, stop, reg2, wdon, trig;
  logic        rlh, rds, lls, sense, hs, cwake, ons, obo, ct;
  logic [3:0]  wpe;
  logic [4:0]  cyc;
  logic [5:0]  wdp;
  logic [15:0] cw;
  int          fails, checks, trigs, t0;
  scw_row_s    rows [10] = '{
    '{16'h1FE1, 6'd16, 16'h1FE1, 1'b1, 7'h07, 24'hFF0000, 24'hFF0000},
    '{16'h002A, 6'd16, 16'h002A, 1'b1, 7'h07, 24'h008000, 24'h008000},
    '{16'h3FF3, 6'd16, 16'h3FF3, 1'b1, 7'h07, 24'h007FC0, 24'h007FC0},
    '{16'h47FC, 6'd16, 16'h47FC, 1'b1, 7'h46, 24'h00003F, 24'h00003F},
    '{16'h803D, 6'd16, 16'h803D, 1'b1, 7'h17, 24'h000001, 24'h00003F},
    '{16'h005E, 6'd16, 16'h005E, 1'b1, 7'h0F, 24'h000002, 24'h00003F},
    '{16'h801F, 6'd16, 16'h801F, 1'b1, 7'h25, 24'h000002, 24'h00003F},
    '{16'h0008, 6'd16, 16'h0008, 1'b1, 7'h03, 24'h000000, 24'h008000},
    '{16'h1FE1, 6'd17, 16'h0008, 1'b0, 7'h03, 24'h000000, 24'h000000},
    '{16'h0003, 6'd32, 16'h0003, 1'b1, 7'h07, 24'h000000, 24'hFF0000}
  };
  scw_master scw_master_inst (.sclk_out(sclk), .select_n_out(sel_n), .sdi_out(sdi));
  scw_decoder scw_decoder_inst (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .select_n_in(sel_n),
    .serial_data_in(sdi), .supply_fail_in(supply_fail_in), .status_active_in(16'hA5C3),
    .status_wake_in(16'h3C5A), .wake_event_in(1'b0), .serial_data_out(sdo),
    .serial_data_oe_out(oe), .wake_output_n_out(wake_n), .control_word_out(cw),
    .word_valid_out(valid), .can_on_out(), .lin_on_out(), .can_rxonly_out(canro),
    .lin_rxonly_out(linro), .chip_sleep_out(sleep), .chip_stop_out(stop),
    .second_regulator_out(reg2), .watchdog_on_out(wdon), .reset_level_high_out(rlh),
    .reset_delay_short_out(rds), .lin_low_slope_out(lls), .wake_pin_en_out(wpe),
    .sense_on_out(sense), .high_side_output_out(hs), .cyclic_period_out(cyc),
    .cyclic_wake_out(cwake), .hs_ontime_short_out(ons), .hs_off_by_ontime_out(obo),
    .cont_timer_out(ct), .wdog_period_out(wdp), .wdog_trigger_out(trig));
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic pulse(ref logic sig);
    @(negedge mclk_in) sig = 1'b1;
    repeat (5) @(negedge mclk_in);
    sig = 1'b0;
    repeat (10) @(negedge mclk_in);
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (trig === 1'b1) trigs++;
  end
  initial begin
    #200us;
    fails++;
    give_verdict();
  end
  initial begin
    sys_rst_in     = 1'b1;
    supply_fail_in = 1'b0;
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in) sys_rst_in = 1'b0;
    repeat (5) @(negedge mclk_in);
    foreach (rows[i]) begin
      fork
        scw_master_inst.frame(rows[i].word, int'(rows[i].nclk));
        if (i > 0 && rows[i-1].wake_n === 1'b0) begin
          #60;
          check(oe === 1'b1 && sdo === 1'b1, "no error mark on data out");
        end
      join
      check(cw === rows[i].cw, "control word");
      check(wake_n === rows[i].wake_n, "wake output");
      check({sleep, stop, canro, linro, valid, reg2, wdon} === rows[i].modes, "modes");
      check(({rlh, rds, lls, wpe, sense, hs, cyc, cwake, ons, obo, ct, wdp} & rows[i].mask)
        === rows[i].set, "settings");
    end
    t0 = trigs;
    scw_master_inst.frame(16'h47FC, 16);
    check(trigs == t0 + 1, "watchdog trigger missing");
    scw_master_inst.frame(16'h47FC, 15);
    check(trigs == t0 + 1 && wake_n === 1'b0, "bad frame triggered");
    pulse(supply_fail_in);
    check(cw === scw_pkg::CTRL_RST && wdp === 6'h01, "supply fail restore");
    pulse(sys_rst_in);
    check(wake_n === 1'b1 && oe === 1'b0 && cw === scw_pkg::CTRL_RST, "reset values");
    scw_master_inst.frame(16'h002A, 16);
    check(cw === 16'h002A && hs === 1'b1, "frame after reset");
    give_verdict();
  end
endmodule
